// file: rtl/isp_pkg.sv
// Shared constants and types for the in-system flash programmer
package isp_pkg;
   // Register indices; the bus byte address is four times the index
   localparam logic [7:0] IDX_SYS  = 8'hbf;
   localparam logic [7:0] IDX_AH   = 8'hf4;
   localparam logic [7:0] IDX_AL   = 8'hf5;
   localparam logic [7:0] IDX_DATA = 8'hf6;
   localparam logic [7:0] IDX_CTRL = 8'hf7;
   localparam logic [7:0] IDX_STAT = 8'hf8;
   localparam int         IDX_LSB  = 2;
   localparam int         IDX_MSB  = 9;
   // Field positions and writable masks
   localparam int         SYS_EN   = 2;
   localparam logic [7:0] SYS_MASK = 8'h8f;
   localparam int         CTL_GO   = 7;
   localparam int         CTL_UPR  = 5;
   localparam logic [7:0] CTL_MASK = 8'h23;
   localparam int         ST_BUSY  = 0;
   localparam int         ST_PROT  = 1;
   localparam int         ST_OPEN  = 2;
   localparam int         ST_ENTRY = 3;
   localparam logic [7:0] RST_BYTE = 8'h00;
   // Unlock key bytes
   localparam logic [7:0] KEY_A    = 8'h55;
   localparam logic [7:0] KEY_B    = 8'haa;
   // Flash geometry
   localparam int          PAGE_BITS = 9;
   localparam logic [3:0]  LOCK_MAX  = 4'h8;
   localparam logic [16:0] PROG_TOP  = 17'h10000;
   localparam logic [7:0]  ERASED    = 8'hff;
   localparam logic [7:0]  PROT_READ = 8'h00;
   localparam logic [15:0] BOOT_ADDR = 16'h0000;
   // Bus encodings
   localparam logic [2:0]  HSIZE_WORD = 3'b010;
   localparam logic        HRESP_OKAY = 1'b0;
   typedef enum logic [1:0] {
      OP_PROG = 2'b00,
      OP_PROT = 2'b01,
      OP_PAGE = 2'b10,
      OP_CHIP = 2'b11
   } op_t;
   typedef enum logic [1:0] {
      UL_IDLE = 2'b00,
      UL_ONE  = 2'b01,
      UL_TWO  = 2'b10,
      UL_OPEN = 2'b11
   } unlock_t;
   typedef enum logic [1:0] {
      EN_IDLE  = 2'b00,
      EN_CHECK = 2'b01,
      EN_REQ   = 2'b10
   } eng_t;
endpackage

// file: rtl/flash_op_if.sv
// Launch and completion signals between register file and engine
`timescale 1ns/100ps
interface flash_op_if;
   logic             start;
   isp_pkg::op_t     op;
   logic [16:0]      addr;
   logic [7:0]       data;
   logic [16:0]      svc_start;
   logic             done;
   logic             pset;
   logic             pclr;
   modport ctl (output start, op, addr, data, svc_start,
                input  done, pset, pclr);
   modport eng (input  start, op, addr, data, svc_start,
                output done, pset, pclr);
endinterface

// file: rtl/flash_op_engine.sv
// Sequencer that turns one launched operation into flash array requests
`timescale 1ns/100ps
module flash_op_engine (
   input  wire logic        clk,      // System clock
   input  wire logic        srst,     // Sync reset, high
   flash_op_if.eng          ep,       // Launch port
   output logic             fl_req,   // Array request level
   output logic             fl_erase, // 1 page erase, 0 program
   output logic [16:0]      fl_addr,  // Array address
   output logic [7:0]       fl_wdata, // Program byte
   input  wire logic        fl_done   // Array finished, pulse
);
   isp_pkg::eng_t st_r, st_nxt;
   isp_pkg::op_t  op_r, op_nxt;
   logic [16:0] addr_r, addr_nxt, cur;
   logic [7:0]  data_r, data_nxt, page_r, page_nxt;
   logic        done_r, done_nxt, pset_r, pset_nxt, pclr_r, pclr_nxt;
   logic        era_r, era_nxt;
   logic [16:0] fa_r, fa_nxt;
   logic        hit_cur, hit_new;

   // Lock area test: program half at or above the service start
   function automatic logic locked(input logic [16:0] a,
                                   input logic [16:0] s);
      locked = !a[16] && ({1'b0, a[15:0]} >= s);
   endfunction

   assign cur     = (op_r == isp_pkg::OP_CHIP) ?
                    {page_r, {isp_pkg::PAGE_BITS{1'b0}}} :
                    (op_r == isp_pkg::OP_PAGE) ?
                    {addr_r[16:isp_pkg::PAGE_BITS],
                     {isp_pkg::PAGE_BITS{1'b0}}} : addr_r;
   assign hit_cur = locked(cur, ep.svc_start);
   assign hit_new = locked(ep.addr, ep.svc_start);

   // Next-state logic of the sequencer
   always_comb begin
      st_nxt   = st_r;
      op_nxt   = op_r;
      addr_nxt = addr_r;
      data_nxt = data_r;
      page_nxt = page_r;
      era_nxt  = era_r;
      fa_nxt   = fa_r;
      done_nxt = 1'b0;
      pset_nxt = 1'b0;
      pclr_nxt = 1'b0;
      unique case (st_r)
         isp_pkg::EN_IDLE: begin
            if (ep.start) begin
               op_nxt   = ep.op;
               addr_nxt = ep.addr;
               data_nxt = ep.data;
               page_nxt = 8'h00;
               st_nxt   = isp_pkg::EN_CHECK;
            end
         end
         isp_pkg::EN_CHECK: begin
            fa_nxt  = cur;
            era_nxt = (op_r != isp_pkg::OP_PROG);
            if (op_r == isp_pkg::OP_PROT) begin
               pset_nxt = 1'b1;
               done_nxt = 1'b1;
               st_nxt   = isp_pkg::EN_IDLE;
            end else if (!hit_cur) begin
               st_nxt = isp_pkg::EN_REQ;
            end else if (op_r == isp_pkg::OP_CHIP && page_r != 8'hff) begin
               page_nxt = page_r + 8'h01;
            end else begin
               pclr_nxt = (op_r == isp_pkg::OP_CHIP);
               done_nxt = 1'b1;
               st_nxt   = isp_pkg::EN_IDLE;
            end
         end
         isp_pkg::EN_REQ: begin
            // chip erase walks every page of both halves
            if (fl_done) begin
               if (op_r == isp_pkg::OP_CHIP && page_r != 8'hff) begin
                  page_nxt = page_r + 8'h01;
                  st_nxt   = isp_pkg::EN_CHECK;
               end else begin
                  pclr_nxt = (op_r == isp_pkg::OP_CHIP);
                  done_nxt = 1'b1;
                  st_nxt   = isp_pkg::EN_IDLE;
               end
            end
         end
         default: st_nxt = isp_pkg::EN_IDLE;
      endcase
   end

   // Sequencer registers
   always_ff @(posedge clk) begin
      if (srst) begin
         st_r   <= isp_pkg::EN_IDLE;
         op_r   <= isp_pkg::OP_PROG;
         addr_r <= '0;
         data_r <= isp_pkg::RST_BYTE;
         page_r <= 8'h00;
         era_r  <= 1'b0;
         fa_r   <= '0;
         done_r <= 1'b0;
         pset_r <= 1'b0;
         pclr_r <= 1'b0;
      end else begin
         st_r   <= st_nxt;
         op_r   <= op_nxt;
         addr_r <= addr_nxt;
         data_r <= data_nxt;
         page_r <= page_nxt;
         era_r  <= era_nxt;
         fa_r   <= fa_nxt;
         done_r <= done_nxt;
         pset_r <= pset_nxt;
         pclr_r <= pclr_nxt;
      end
   end

   assign fl_req   = (st_r == isp_pkg::EN_REQ);
   assign fl_erase = era_r;
   assign fl_addr  = fa_r;
   assign fl_wdata = data_r;
   assign ep.done  = done_r;
   assign ep.pset  = pset_r;
   assign ep.pclr  = pclr_r;

   // no request into the lock area
   lock_keep_a: assert property (
      @(posedge clk) disable iff (srst)
      fl_req |-> !locked(fl_addr, ep.svc_start))
      else $error("flash request hits the locked area");

   prog_data_a: assert property (
      @(posedge clk) disable iff (srst)
      (st_r == isp_pkg::EN_IDLE && ep.start &&
       ep.op == isp_pkg::OP_PROG && !hit_new)
      |-> ##2 (fl_req && !fl_erase && fl_wdata == $past(ep.data, 2)
               && fl_addr == $past(ep.addr, 2)))
      else $error("byte program did not reach the array");

   page_align_a: assert property (
      @(posedge clk) disable iff (srst)
      (fl_req && fl_erase) |-> fl_addr[isp_pkg::PAGE_BITS-1:0] == '0)
      else $error("erase address not page aligned");
endmodule

// file: rtl/insystem_flash_programmer.sv
// In-system flash programmer: register file, unlock, boot entry
// Contract
// - Global enable bit 2 permits all flash operations; zero disables them.
// - Service area lies in F000..FFFF, sized N times 512, N 0..8.
// - N of zero reserves nothing; whole program flash is ordinary.
// - N of eight reserves 4K, leaving 60K ordinary program memory.
// - Service area grows down from FFFF; start is Fx00, x even.
// - Chip erase clears both halves except the locked service area.
// - Written service area stays locked against every in-system erase.
// - Read protection returns zeros; otherwise reads return stored bytes.
// - Reset with location zero blank loads PC with service start.
// - Any forcing pin low during reset starts the service code.
// - Service entry allowed active or idle, never in power-down.
// - Target address is 16 bits: high register over low register.
// - Program or page erase inside service area changes nothing.
// - Byte program writes the data register to the target address.
// - Data register is an 8-bit read/write operand register.
// - Operation field: 00 program, 01 protect, 10 page, 11 chip.
// - Start bit stays read-only until 55, AA, 55 written to data.
// - Start latches operands, stalls CPU, self-clears at completion.
// - Upper-array bit selects data flash, acting as address bit 16.
`timescale 1ns/100ps
module insystem_flash_programmer (
   input  wire logic        clk,           // 200 MHz system clock
   input  wire logic        srst,          // Sync reset, high
   input  wire logic        hsel,          // AHB slave select
   input  wire logic [31:0] haddr,         // AHB address
   input  wire logic [1:0]  htrans,        // AHB transfer type
   input  wire logic        hwrite,        // AHB write
   input  wire logic [2:0]  hsize,         // AHB size
   input  wire logic [31:0] hwdata,        // AHB write data
   input  wire logic        hready,        // AHB bus ready
   output logic             hreadyout,     // Slave ready
   output logic [31:0]      hrdata,        // Read data
   output logic             hresp,         // Always OKAY
   input  wire logic        force_entry_pin_a_n, // Strap pin, low
   input  wire logic        force_entry_pin_b_n, // Strap pin, low
   input  wire logic        force_entry_pin_c_n, // Strap pin, low
   input  wire logic        power_down,    // Core in power-down
   input  wire logic [3:0]  lock_size_nv,  // Nonvolatile lock size
   input  wire logic [7:0]  first_byte,    // Flash byte at zero
   output logic             pc_load,       // Load PC, pulse
   output logic [15:0]      pc_load_addr,  // PC value to load
   output logic             cpu_stall,     // Hold program counter
   input  wire logic [7:0]  fl_rd_data,    // Raw array read byte
   output logic [7:0]       cpu_rd_data,   // Filtered read byte
   output logic             fl_req,        // Array request level
   output logic             fl_erase,      // Page erase, else program
   output logic [16:0]      fl_addr,       // Array address
   output logic [7:0]       fl_wdata,      // Program byte
   input  wire logic        fl_done        // Array done, pulse
);
   flash_op_if ep ();

   logic [7:0]  sys_r, sys_nxt, ah_r, ah_nxt, al_r, al_nxt;
   logic [7:0]  data_r, data_nxt, ctrl_r, ctrl_nxt;
   logic [7:0]  rd_r, rd_nxt, stat, wb, rsel;
   logic [31:0] hrdata_r, hrdata_nxt;
   logic [7:0]  widx_r, widx_nxt;
   logic        wpend_r, wpend_nxt, prot_r, prot_nxt, go;
   logic        acc, mapped, busy;
   isp_pkg::unlock_t ul_r, ul_nxt;
   logic [3:0]  lock_n;
   logic [16:0] svc_start;
   logic [2:0]  pin_s1, pin_s2;
   logic        srst_d_r, forced_r, forced_nxt;
   logic        entry_r, entry_nxt, pcl_r, pcl_nxt;
   logic [15:0] pca_r, pca_nxt;

   // lock size clamped to eight blocks
   assign lock_n = (lock_size_nv > isp_pkg::LOCK_MAX) ?
                   isp_pkg::LOCK_MAX : lock_size_nv;
   // start grows down from top; N of zero gives top itself
   assign svc_start = isp_pkg::PROG_TOP -
                      {4'h0, lock_n, {isp_pkg::PAGE_BITS{1'b0}}};

   // Zero-wait slave; only whole-word transfers are taken
   assign acc    = hsel && htrans[1] && hready &&
                   hsize == isp_pkg::HSIZE_WORD;
   assign mapped = haddr[31:isp_pkg::IDX_MSB+1] == '0 &&
                   haddr[isp_pkg::IDX_LSB-1:0] == '0;
   assign wb     = hwdata[7:0];
   assign busy   = ctrl_r[isp_pkg::CTL_GO];

   // Status byte shows engine and unlock state
   always_comb begin
      stat = 8'h00;
      stat[isp_pkg::ST_BUSY]  = busy;
      stat[isp_pkg::ST_PROT]  = prot_r;
      stat[isp_pkg::ST_OPEN]  = (ul_r == isp_pkg::UL_OPEN);
      stat[isp_pkg::ST_ENTRY] = entry_r;
      stat[7:4] = lock_n;
   end

   // Read mux; unmapped offsets read zero
   always_comb begin
      rsel = 8'h00;
      if (mapped) begin
         unique case (haddr[isp_pkg::IDX_MSB:isp_pkg::IDX_LSB])
            isp_pkg::IDX_SYS:  rsel = sys_r;
            isp_pkg::IDX_AH:   rsel = ah_r;
            isp_pkg::IDX_AL:   rsel = al_r;
            isp_pkg::IDX_DATA: rsel = data_r;
            isp_pkg::IDX_CTRL: rsel = ctrl_r;
            isp_pkg::IDX_STAT: rsel = stat;
            default:           rsel = 8'h00;
         endcase
      end
   end

   // Register file next values
   always_comb begin
      sys_nxt    = sys_r;
      ah_nxt     = ah_r;
      al_nxt     = al_r;
      data_nxt   = data_r;
      ctrl_nxt   = ctrl_r;
      ul_nxt     = ul_r;
      prot_nxt   = prot_r;
      go         = 1'b0;
      wpend_nxt  = acc && hwrite && mapped;
      widx_nxt   = haddr[isp_pkg::IDX_MSB:isp_pkg::IDX_LSB];
      hrdata_nxt = (acc && !hwrite) ? {24'h0, rsel} : hrdata_r;
      if (wpend_r) begin
         unique case (widx_r)
            isp_pkg::IDX_SYS:  sys_nxt = wb & isp_pkg::SYS_MASK;
            isp_pkg::IDX_AH:   ah_nxt = wb;
            isp_pkg::IDX_AL:   al_nxt = wb;
            isp_pkg::IDX_DATA: begin
               // plain operand byte, also feeds the key check
               data_nxt = wb;
               // key sequence opens the start bit
               unique case (ul_r)
                  isp_pkg::UL_IDLE:
                     ul_nxt = (wb == isp_pkg::KEY_A) ?
                              isp_pkg::UL_ONE : isp_pkg::UL_IDLE;
                  isp_pkg::UL_ONE:
                     ul_nxt = (wb == isp_pkg::KEY_B) ? isp_pkg::UL_TWO :
                              (wb == isp_pkg::KEY_A) ? isp_pkg::UL_ONE :
                              isp_pkg::UL_IDLE;
                  isp_pkg::UL_TWO:
                     ul_nxt = (wb == isp_pkg::KEY_A) ?
                              isp_pkg::UL_OPEN : isp_pkg::UL_IDLE;
                  isp_pkg::UL_OPEN: ul_nxt = isp_pkg::UL_OPEN;
               endcase
            end
            isp_pkg::IDX_CTRL: begin
               // Control is frozen while an operation runs
               if (!busy) begin
                  ctrl_nxt = wb & isp_pkg::CTL_MASK;
                  if (wb[isp_pkg::CTL_GO] && ul_r == isp_pkg::UL_OPEN &&
                      sys_r[isp_pkg::SYS_EN]) begin
                     go = 1'b1;
                     ctrl_nxt[isp_pkg::CTL_GO] = 1'b1;
                  end
               end
            end
            default: ;
         endcase
      end
      // start bit clears itself at completion
      if (ep.done) begin
         ctrl_nxt[isp_pkg::CTL_GO] = 1'b0;
      end
      // protect sets the flag, chip erase clears it
      if (ep.pclr) begin
         prot_nxt = 1'b0;
      end
      if (ep.pset) begin
         prot_nxt = 1'b1;
      end
      rd_nxt = prot_r ? isp_pkg::PROT_READ : fl_rd_data;
   end

   // Register file state
   always_ff @(posedge clk) begin
      if (srst) begin
         sys_r    <= isp_pkg::RST_BYTE;
         ah_r     <= isp_pkg::RST_BYTE;
         al_r     <= isp_pkg::RST_BYTE;
         data_r   <= isp_pkg::RST_BYTE;
         ctrl_r   <= isp_pkg::RST_BYTE;
         ul_r     <= isp_pkg::UL_IDLE;
         prot_r   <= 1'b0;
         wpend_r  <= 1'b0;
         widx_r   <= 8'h00;
         hrdata_r <= 32'h0;
         rd_r     <= isp_pkg::RST_BYTE;
      end else begin
         sys_r    <= sys_nxt;
         ah_r     <= ah_nxt;
         al_r     <= al_nxt;
         data_r   <= data_nxt;
         ctrl_r   <= ctrl_nxt;
         ul_r     <= ul_nxt;
         prot_r   <= prot_nxt;
         wpend_r  <= wpend_nxt;
         widx_r   <= widx_nxt;
         hrdata_r <= hrdata_nxt;
         rd_r     <= rd_nxt;
      end
   end

   // Launch port toward the engine
   assign ep.start = go;
   assign ep.op    = isp_pkg::op_t'(wb[1:0]);
   // upper-array bit is address bit 16
   assign ep.addr  = {wb[isp_pkg::CTL_UPR], ah_r, al_r};
   assign ep.data  = data_r;
   assign ep.svc_start = svc_start;

   flash_op_engine u_eng (
      .clk      (clk),
      .srst     (srst),
      .ep       (ep.eng),
      .fl_req   (fl_req),
      .fl_erase (fl_erase),
      .fl_addr  (fl_addr),
      .fl_wdata (fl_wdata),
      .fl_done  (fl_done)
   );

   // Strap synchroniser; runs through reset so pins are seen during it
   always_ff @(posedge clk) begin
      pin_s1   <= {force_entry_pin_c_n, force_entry_pin_b_n,
                   force_entry_pin_a_n};
      pin_s2   <= pin_s1;
      srst_d_r <= srst;
      forced_r <= forced_nxt;
   end

   // strap caught during reset, judged at release
   always_comb begin
      forced_nxt = srst ? !(&pin_s2) : forced_r;
      entry_nxt  = entry_r;
      pcl_nxt    = 1'b0;
      pca_nxt    = pca_r;
      if (srst_d_r && !srst) begin
         // blank or strapped, not in power-down
         if ((forced_r || first_byte == isp_pkg::ERASED) &&
             !power_down && !svc_start[16]) begin
            entry_nxt = 1'b1;
            pcl_nxt   = 1'b1;
            pca_nxt   = svc_start[15:0];
         end
      end
   end

   // Boot entry state
   always_ff @(posedge clk) begin
      if (srst) begin
         entry_r <= 1'b0;
         pcl_r   <= 1'b0;
         pca_r   <= isp_pkg::BOOT_ADDR;
      end else begin
         entry_r <= entry_nxt;
         pcl_r   <= pcl_nxt;
         pca_r   <= pca_nxt;
      end
   end

   assign hreadyout    = 1'b1;
   assign hresp        = isp_pkg::HRESP_OKAY;
   assign hrdata       = hrdata_r;
   assign cpu_stall    = busy;
   assign cpu_rd_data  = rd_r;
   assign pc_load      = pcl_r;
   assign pc_load_addr = pca_r;

   en_gate_a: assert property (
      @(posedge clk) disable iff (srst)
      ep.start |-> sys_r[isp_pkg::SYS_EN])
      else $error("launch with global enable cleared");

   // no launch before the key sequence
   key_gate_a: assert property (
      @(posedge clk) disable iff (srst)
      (ul_r != isp_pkg::UL_OPEN) |=> !$rose(cpu_stall))
      else $error("start bit set without key sequence");

   // stall rises after launch and drops only on completion
   stall_hold_a: assert property (
      @(posedge clk) disable iff (srst)
      (ep.start || (cpu_stall && !ep.done)) |=> cpu_stall)
      else $error("stall dropped before completion");

   prot_read_a: assert property (
      @(posedge clk) disable iff (srst)
      prot_r |=> cpu_rd_data == isp_pkg::PROT_READ)
      else $error("protected read leaked data");

   // unprotected reads pass the array byte
   open_read_a: assert property (
      @(posedge clk) disable iff (srst)
      !prot_r |=> cpu_rd_data == $past(fl_rd_data))
      else $error("unprotected read altered");

   // entry address has the Fx00 form with x even
   entry_form_a: assert property (
      @(posedge clk) disable iff (srst)
      pc_load |-> (pc_load_addr[15:12] == 4'hf &&
                   pc_load_addr[8:0] == 9'h000))
      else $error("service start address malformed");

   pd_block_a: assert property (
      @(posedge clk) disable iff (srst)
      pc_load |-> !$past(power_down))
      else $error("service entry during power-down");

   // array address is high register over low register
   addr_join_a: assert property (
      @(posedge clk) disable iff (srst)
      (ep.start && ep.op == isp_pkg::OP_PROG &&
       (ep.addr[16] || {1'b0, ah_r, al_r} < svc_start))
      |-> ##2 (fl_req &&
               fl_addr[15:0] == {$past(ah_r, 2), $past(al_r, 2)}))
      else $error("target address not formed from registers");
endmodule

// file: test/flash_array_model.sv
// Behavioural flash array answering the sequencer's requests
`timescale 1ns/100ps
module flash_array_model (
   input  wire logic        clk,        // System clock
   input  wire logic        fl_req,     // Request level
   input  wire logic        fl_erase,   // Page erase, else program
   input  wire logic [16:0] fl_addr,    // Array address
   input  wire logic [7:0]  fl_wdata,   // Program byte
   input  wire logic [31:0] lat,        // Extra cycles before done
   output logic             fl_done,    // Done pulse
   output logic [7:0]       fl_rd_data, // Byte at fl_addr
   output int               n_req       // Requests served
);
   logic [7:0] mem [0:131071];
   int         cnt;
   // Blank array at start
   initial begin
      foreach (mem[i]) mem[i] = 8'hff;
      fl_done = 1'b0;
      cnt = 0;
      n_req = 0;
   end
   assign fl_rd_data = mem[fl_addr];
   // One answer per request; the done pulse blocks a stale retrigger
   always @(posedge clk) begin
      fl_done <= 1'b0;
      if (fl_req && !fl_done) begin
         if (cnt < lat) cnt <= cnt + 1;
         else begin
            cnt <= 0;
            fl_done <= 1'b1;
            n_req <= n_req + 1;
            if (fl_erase) begin
               for (int i = 0; i < 512; i++)
                  mem[{fl_addr[16:9], 9'(i)}] <= 8'hff;
            end
            else mem[fl_addr] <= fl_wdata;
         end
      end
   end
endmodule

// file: test/insystem_flash_programmer_test.sv
// Register-level testbench for the in-system flash programmer
`timescale 1ns/100ps
module insystem_flash_programmer_test;
   logic        clk, srst, hsel, hwrite, hreadyout, hresp, pc_load;
   logic        pa, pb, pc_n, pd, cpu_stall, fl_req, fl_erase, fl_done;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [3:0]  lock_n;
   logic [7:0]  fb, fl_rd_data, cpu_rd, fl_wdata;
   logic [15:0] pc_addr;
   logic [16:0] fl_addr;
   int          lat, n_req, n_fail, checks_done;

   insystem_flash_programmer dut_u (.clk, .srst, .hsel, .haddr, .htrans,
      .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hrdata,
      .hresp, .force_entry_pin_a_n(pa), .force_entry_pin_b_n(pb),
      .force_entry_pin_c_n(pc_n), .power_down(pd), .lock_size_nv(lock_n),
      .first_byte(fb), .pc_load, .pc_load_addr(pc_addr), .cpu_stall,
      .fl_rd_data, .cpu_rd_data(cpu_rd), .fl_req, .fl_erase, .fl_addr,
      .fl_wdata, .fl_done);
   flash_array_model model_u (.clk, .fl_req, .fl_erase, .fl_addr,
      .fl_wdata, .lat, .fl_done, .fl_rd_data, .n_req);

   task automatic chk(input string nm, input logic [31:0] exp, got);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // Single AHB word transfer; waits on hready rather than assuming 0 wait
   task automatic xfer(input logic w, input logic [7:0] idx, d);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= {22'h0, idx, 2'b00};
      hwrite <= w;
      htrans <= 2'b10;
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= {24'h0, d};
      do @(posedge clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   // Launch through the control register and wait for the stall to end
   task automatic go(input logic [7:0] c);
      xfer(1'b1, isp_pkg::IDX_CTRL, c);
      repeat (3) @(posedge clk);
      while (cpu_stall !== 1'b0) @(posedge clk);
   endtask
   // Straps and blank byte are set before reset, judged at release
   // Straps are {c, b, a}, active low
   task automatic boot(input logic [3:0] n, input logic [7:0] b,
                       input logic [2:0] p, input logic w,
                       input logic [15:0] exp);
      lock_n <= n;
      fb <= b;
      {pc_n, pb, pa} <= p;
      pd <= w;
      srst <= 1'b1;
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      // Entry pulse stands in the second cycle after release
      @(posedge clk);
      @(negedge clk);
      chk("pc_load", {31'h0, exp != 16'h0}, {31'h0, pc_load});
      repeat (2) @(posedge clk);
      chk("pc_load_addr", {16'h0, exp}, {16'h0, pc_addr});
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // Whole run is about a thousand cycles; this cuts a hang short
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      end_sim();
   end

   initial begin
      srst = 1'b1;
      hsel = 1'b0;
      haddr = '0;
      htrans = '0;
      hwrite = 1'b0;
      hsize = isp_pkg::HSIZE_WORD;
      hwdata = '0;
      lat = 2;
      n_fail = 0;
      checks_done = 0;
      boot(4'h2, 8'hff, 3'b111, 1'b0, 16'hfc00);
      // Service code placed in the locked area once the array is blank
      model_u.mem[17'h0fc00] = 8'h77;
      xfer(1'b0, isp_pkg::IDX_STAT, 8'h00);
      chk("status", 32'h28, rd);
      xfer(1'b0, isp_pkg::IDX_AH, 8'h00);
      chk("addr_high", 32'h0, rd);
      xfer(1'b0, isp_pkg::IDX_AL, 8'h00);
      chk("addr_low", 32'h0, rd);
      hsize <= 3'h0;
      xfer(1'b1, isp_pkg::IDX_AL, 8'h5a);
      hsize <= isp_pkg::HSIZE_WORD;
      xfer(1'b0, isp_pkg::IDX_AL, 8'h00);
      chk("byte write ignored", 32'h0, rd);
      xfer(1'b1, isp_pkg::IDX_DATA, 8'ha5);
      xfer(1'b0, isp_pkg::IDX_DATA, 8'h00);
      chk("prog_data", 32'ha5, rd);
      xfer(1'b1, isp_pkg::IDX_SYS, 8'h04);
      xfer(1'b1, isp_pkg::IDX_AH, 8'h10);
      xfer(1'b1, isp_pkg::IDX_AL, 8'h05);
      go(8'h80);
      chk("no key", 32'd0, n_req);
      xfer(1'b1, isp_pkg::IDX_DATA, isp_pkg::KEY_A);
      xfer(1'b1, isp_pkg::IDX_DATA, isp_pkg::KEY_B);
      xfer(1'b1, isp_pkg::IDX_DATA, isp_pkg::KEY_A);
      xfer(1'b1, isp_pkg::IDX_DATA, 8'h22);
      xfer(1'b1, isp_pkg::IDX_SYS, 8'h00);
      go(8'h80);
      chk("disabled", 32'd0, n_req);
      xfer(1'b1, isp_pkg::IDX_SYS, 8'h04);
      go(8'h80);
      chk("program", 32'h22, model_u.mem[17'h01005]);
      xfer(1'b0, isp_pkg::IDX_CTRL, 8'h00);
      chk("start self clear", 32'h0, rd);
      chk("open read", 32'h22, cpu_rd);
      xfer(1'b1, isp_pkg::IDX_DATA, 8'h3c);
      go(8'ha0);
      chk("data flash", 32'h3c, model_u.mem[17'h11005]);
      xfer(1'b1, isp_pkg::IDX_AH, 8'hfc);
      xfer(1'b1, isp_pkg::IDX_AL, 8'h00);
      go(8'h80);
      go(8'h82);
      chk("locked requests", 32'd2, n_req);
      xfer(1'b1, isp_pkg::IDX_AH, 8'h11);
      xfer(1'b1, isp_pkg::IDX_AL, 8'hff);
      go(8'h82);
      chk("page erase", 32'hff, model_u.mem[17'h01005]);
      go(8'h81);
      xfer(1'b0, isp_pkg::IDX_STAT, 8'h00);
      chk("protect flag", 32'h2e, rd);
      chk("protected read", 32'h0, cpu_rd);
      lat = 0;
      go(8'h83);
      chk("chip erase", 32'd257, n_req);
      chk("erase upper", 32'hff, model_u.mem[17'h11005]);
      chk("service kept", 32'h77, model_u.mem[17'h0fc00]);
      xfer(1'b0, isp_pkg::IDX_STAT, 8'h00);
      chk("unprotected", 32'h2c, rd);
      // Restart by reset as firmware must after the service code
      boot(4'h2, 8'h00, 3'b110, 1'b1, 16'h0000);
      boot(4'h8, 8'h00, 3'b011, 1'b0, 16'hf000);
      boot(4'h4, 8'h00, 3'b101, 1'b0, 16'hf800);
      boot(4'h2, 8'h00, 3'b110, 1'b0, 16'hfc00);
      boot(4'h2, 8'h00, 3'b111, 1'b0, 16'h0000);
      boot(4'h0, 8'hff, 3'b111, 1'b0, 16'h0000);
      end_sim();
   end
endmodule
